// ### hw/bfifo_map.svh
`ifndef BFIFO_MAP_SVH
`define BFIFO_MAP_SVH
`define WORD_W 32
`define DEPTH_W 9
`define CNT_W 10
`define OFF_W 9
`define QUEUE_DEPTH 10'h200
`define OFF_RST 9'h040
`define PRESET_HH 9'h040
`define PRESET_HL 9'h010
`define PRESET_LH 9'h008
`define FS_PROG 2'h0
`define FS_HH 2'h3
`define FS_HL 2'h2
`define FS_LH 2'h1
`define IR_DELAY 2'h2
`endif

// ### hw/bfifo_pkg.sv
`default_nettype none
`include "bfifo_map.svh"
package bfifo_pkg;
	typedef logic [`WORD_W-1:0] word_t;
	typedef logic [`DEPTH_W-1:0] ptr_t;
	typedef logic [`CNT_W-1:0] cnt_t;
	typedef logic [`OFF_W-1:0] off_t;
	typedef enum logic [2:0] {
		PG_FWD_AF = 3'b000,
		PG_FWD_AE = 3'b001,
		PG_REV_AF = 3'b010,
		PG_REV_AE = 3'b011,
		PG_DONE = 3'b100
	} prog_state_t;
endpackage
`default_nettype wire

// ### hw/queue_if.sv
`timescale 1ns/1ns
`default_nettype none
interface queue_if;
	import bfifo_pkg::*;
	logic rst;
	logic hold;
	logic wr;
	logic pop;
	word_t wdata;
	word_t dout;
	off_t ae_off;
	off_t af_off;
	logic irdy;
	logic ordy;
	logic ae_n;
	logic af_n;
	modport ctl (output rst, hold, wr, pop, wdata, ae_off, af_off, input dout, irdy, ordy, ae_n, af_n);
	modport eng (input rst, hold, wr, pop, wdata, ae_off, af_off, output dout, irdy, ordy, ae_n, af_n);
endinterface
`default_nettype wire

// ### hw/word_ram.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfifo_map.svh"
module word_ram
	import bfifo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic we,
	input wire ptr_t waddr,
	input wire word_t wdata,
	input wire logic re,
	input wire ptr_t raddr,
	output word_t rdata
);
	word_t mem [0:`QUEUE_DEPTH-1];
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
	// Read data register doubles as the queue output register
	always_ff @(posedge sys_clk) begin
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule // word_ram
`default_nettype wire

// ### hw/queue_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfifo_map.svh"
module queue_engine
	import bfifo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic clk_en,
	queue_if.eng q
);
	ptr_t wptr_r;
	ptr_t rptr_r;
	cnt_t cnt_r;
	logic [1:0] wait_r;
	logic ordy_r;
	wire logic full = (cnt_r == `QUEUE_DEPTH);
	wire logic load = (cnt_r != '0) && (!ordy_r || q.pop);
	wire logic wr_ok = q.wr && q.irdy;
	wire cnt_t wr_inc = {{(`CNT_W-1){1'b0}}, wr_ok};
	wire cnt_t ld_dec = {{(`CNT_W-1){1'b0}}, load};
	wire cnt_t af_lim = `QUEUE_DEPTH - {1'b0, q.af_off};
	assign q.irdy = !q.rst && !q.hold && (wait_r == `IR_DELAY) && !full;
	assign q.ordy = ordy_r && !q.rst;
	assign q.ae_n = !q.rst && (cnt_r > {1'b0, q.ae_off});
	assign q.af_n = q.rst || (cnt_r < af_lim);
	always_ff @(posedge sys_clk) begin
		if (q.rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
			wait_r <= '0;
			ordy_r <= 1'b0;
		end else if (clk_en) begin
			if (wr_ok) wptr_r <= wptr_r + 1'b1;
			if (load) rptr_r <= rptr_r + 1'b1;
			cnt_r <= cnt_r + wr_inc - ld_dec;
			if (wait_r != `IR_DELAY) wait_r <= wait_r + 2'h1;
			if (load) ordy_r <= 1'b1;
			else if (q.pop) ordy_r <= 1'b0;
		end
	end
	word_ram u_ram (
		.sys_clk(sys_clk),
		.we(clk_en && wr_ok),
		.waddr(wptr_r),
		.wdata(q.wdata),
		.re(clk_en && load),
		.raddr(rptr_r),
		.rdata(q.dout)
	);
	AST_FULL_BLOCKS: assert property (@(posedge sys_clk) disable iff (q.rst) full |-> !q.irdy)
		else $error("input ready high while queue full");
	AST_AUTO_LOAD: assert property (@(posedge sys_clk) disable iff (q.rst)
		clk_en && !ordy_r && cnt_r != '0 |=> q.ordy)
		else $error("stored word not moved to output register");
	AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (q.rst)
		clk_en && wr_ok && !load |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("accepted write not counted");
	COV_FILL: cover property (@(posedge sys_clk) disable iff (q.rst) full);
endmodule // queue_engine
`default_nettype wire

// ### hw/bidir_fifo_ctl.sv
`timescale 1ns/1ns
`default_nettype none
`include "bfifo_map.svh"
// Notes on behaviour
// - Reset clears pointers, drops ready and almost-empty, raises almost-full and mail flag.
// - Input ready rises two clocks after a queue reset ends.
// - Offset select pins are sampled on the rising edge of a queue reset.
// - Four offsets: one almost-empty and one almost-full per queue.
// - Select 11 loads 64, 10 loads 16, 01 loads 8 into both offsets.
// - With presets the two queues may be reset together or apart.
// - First four left queue writes load offsets: fwd full, fwd empty, rev full, rev empty.
// - Offsets come from left data bits 8..0, legal range 1 to 508.
// - After programming, right input ready rises and both queues run.
// - Left bus driven only with chip select low and read selected.
// - Left enabled queue write with input ready stores into forward queue.
// - Left enabled queue read with output ready advances reverse output register.
// - Left mail select picks mailboxes; left mail read releases reverse mail flag.
// - Left and right port transfers proceed independently.
// - Right port mirrors left with inverted direction select.
// - Right enabled queue write with input ready stores into reverse queue.
// - Right enabled queue read with output ready advances forward output register.
// - Right mail select picks mailboxes; right mail read releases forward mail flag.
// - Empty output register reloads by itself, otherwise only on a read.
// - Mailbox write drops its flag, blocks further writes until the far read.
// - Almost-empty while the count is at or below the empty offset.
module bidir_fifo_ctl
	import bfifo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic a_to_b_queue_reset_n,
	input wire logic b_to_a_queue_reset_n,
	input wire logic offset_select_lo,
	input wire logic offset_select_hi,
	input wire logic left_chip_select_n,
	input wire logic left_write_not_read,
	input wire logic left_enable,
	input wire logic left_mail_select,
	input wire word_t left_data_bus_in,
	output word_t left_data_bus_out,
	output logic left_data_oe,
	input wire logic right_chip_select_n,
	input wire logic right_read_not_write,
	input wire logic right_enable,
	input wire logic right_mail_select,
	input wire word_t right_data_bus_in,
	output word_t right_data_bus_out,
	output logic right_data_oe,
	output logic left_input_ready,
	output logic left_output_ready,
	output logic left_almost_empty_n,
	output logic left_almost_full_n,
	output logic right_input_ready,
	output logic right_output_ready,
	output logic right_almost_empty_n,
	output logic right_almost_full_n,
	output logic forward_mail_flag_n,
	output logic reverse_mail_flag_n
);
	queue_if fq ();
	queue_if rq ();

	logic fwd_rstn_r;
	logic rev_rstn_r;
	off_t fwd_ae_r;
	off_t fwd_af_r;
	off_t rev_ae_r;
	off_t rev_af_r;
	prog_state_t pg_r;
	prog_state_t pg_nxt;
	word_t fwd_mbox_r;
	word_t rev_mbox_r;
	logic fmf_r;
	logic rmf_r;

	wire logic fwd_rst = srst || !a_to_b_queue_reset_n;
	wire logic rev_rst = srst || !b_to_a_queue_reset_n;
	wire logic fwd_rise = clk_en && !srst && a_to_b_queue_reset_n && !fwd_rstn_r;
	wire logic rev_rise = clk_en && !srst && b_to_a_queue_reset_n && !rev_rstn_r;
	wire logic [1:0] fs = {offset_select_hi, offset_select_lo};
	wire logic fs_prog = (fs == `FS_PROG);
	wire off_t preset = (fs == `FS_HH) ? `PRESET_HH :
		(fs == `FS_HL) ? `PRESET_HL : `PRESET_LH;
	wire off_t l_off = left_data_bus_in[`OFF_W-1:0];
	wire logic programming = (pg_r != PG_DONE);

	// Left port decode
	wire logic l_sel = !left_chip_select_n && left_enable;
	wire logic l_wr = l_sel && left_write_not_read;
	wire logic l_rd = l_sel && !left_write_not_read;
	wire logic l_wr_q = l_wr && !left_mail_select && left_input_ready;
	wire logic l_rd_q = l_rd && !left_mail_select && left_output_ready;
	wire logic l_wr_m = l_wr && left_mail_select;
	wire logic l_rd_m = l_rd && left_mail_select;
	wire logic prog_wr = l_wr_q && programming;

	// Right port decode, direction select inverted
	wire logic r_wnr = !right_read_not_write;
	wire logic r_sel = !right_chip_select_n && right_enable;
	wire logic r_wr = r_sel && r_wnr;
	wire logic r_rd = r_sel && !r_wnr;
	wire logic r_wr_q = r_wr && !right_mail_select && right_input_ready;
	wire logic r_rd_q = r_rd && !right_mail_select && right_output_ready;
	wire logic r_wr_m = r_wr && right_mail_select;
	wire logic r_rd_m = r_rd && right_mail_select;

	// Queue hookup, each side driven by its own decode; reverse queue input also held while programming runs
	assign fq.rst = fwd_rst;
	assign fq.hold = 1'b0;
	assign fq.wr = l_wr_q && !programming;
	assign fq.pop = r_rd_q;
	assign fq.wdata = left_data_bus_in;
	assign fq.ae_off = fwd_ae_r;
	assign fq.af_off = fwd_af_r;
	assign rq.rst = rev_rst;
	assign rq.hold = programming;
	assign rq.wr = r_wr_q;
	assign rq.pop = l_rd_q;
	assign rq.wdata = right_data_bus_in;
	assign rq.ae_off = rev_ae_r;
	assign rq.af_off = rev_af_r;

	queue_engine u_fwd (
		.sys_clk(sys_clk),
		.clk_en(clk_en),
		.q(fq.eng)
	);
	queue_engine u_rev (
		.sys_clk(sys_clk),
		.clk_en(clk_en),
		.q(rq.eng)
	);

	// Flags
	assign left_input_ready = fq.irdy;
	assign left_almost_full_n = fq.af_n;
	assign right_output_ready = fq.ordy;
	assign right_almost_empty_n = fq.ae_n;
	assign right_input_ready = rq.irdy;
	assign right_almost_full_n = rq.af_n;
	assign left_output_ready = rq.ordy;
	assign left_almost_empty_n = rq.ae_n;
	assign forward_mail_flag_n = fmf_r || fwd_rst;
	assign reverse_mail_flag_n = rmf_r || rev_rst;

	// Data buses
	assign left_data_oe = !left_chip_select_n && !left_write_not_read;
	assign left_data_bus_out = left_mail_select ? rev_mbox_r : rq.dout;
	assign right_data_oe = !right_chip_select_n && !r_wnr;
	assign right_data_bus_out = right_mail_select ? fwd_mbox_r : fq.dout;

	// Reset edge detection
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fwd_rstn_r <= 1'b0;
			rev_rstn_r <= 1'b0;
		end else if (clk_en) begin
			fwd_rstn_r <= a_to_b_queue_reset_n;
			rev_rstn_r <= b_to_a_queue_reset_n;
		end
	end

	// Offset programming sequence
	always_comb begin
		pg_nxt = pg_r;
		if ((fwd_rise || rev_rise) && fs_prog) begin
			pg_nxt = PG_FWD_AF;
		end else if (prog_wr) begin
			case (pg_r)
				PG_FWD_AF: pg_nxt = PG_FWD_AE;
				PG_FWD_AE: pg_nxt = PG_REV_AF;
				PG_REV_AF: pg_nxt = PG_REV_AE;
				PG_REV_AE: pg_nxt = PG_DONE;
				default: pg_nxt = PG_DONE;
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pg_r <= PG_DONE;
		end else if (clk_en) begin
			pg_r <= pg_nxt;
		end
	end

	// Offset registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			fwd_ae_r <= `OFF_RST;
			fwd_af_r <= `OFF_RST;
		end else if (clk_en) begin
			if (fwd_rise && !fs_prog) begin
				fwd_ae_r <= preset;
				fwd_af_r <= preset;
			end else if (prog_wr && pg_r == PG_FWD_AF) begin
				fwd_af_r <= l_off;
			end else if (prog_wr && pg_r == PG_FWD_AE) begin
				fwd_ae_r <= l_off;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rev_ae_r <= `OFF_RST;
			rev_af_r <= `OFF_RST;
		end else if (clk_en) begin
			if (rev_rise && !fs_prog) begin
				rev_ae_r <= preset;
				rev_af_r <= preset;
			end else if (prog_wr && pg_r == PG_REV_AF) begin
				rev_af_r <= l_off;
			end else if (prog_wr && pg_r == PG_REV_AE) begin
				rev_ae_r <= l_off;
			end
		end
	end

	// Mailboxes: a write beats a same-cycle far read
	always_ff @(posedge sys_clk) begin
		if (fwd_rst) begin
			fmf_r <= 1'b1;
		end else if (clk_en) begin
			if (l_wr_m && fmf_r) fmf_r <= 1'b0;
			else if (r_rd_m) fmf_r <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rev_rst) begin
			rmf_r <= 1'b1;
		end else if (clk_en) begin
			if (r_wr_m && rmf_r) rmf_r <= 1'b0;
			else if (l_rd_m) rmf_r <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (clk_en && l_wr_m && fmf_r) fwd_mbox_r <= left_data_bus_in;
		if (clk_en && r_wr_m && rmf_r) rev_mbox_r <= right_data_bus_in;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	AST_RESET_FLAGS: assert property (!a_to_b_queue_reset_n |->
		!left_input_ready && !right_output_ready && !right_almost_empty_n
		&& left_almost_full_n && forward_mail_flag_n)
		else $error("forward queue flags wrong during reset");
	AST_IR_DELAY: assert property ((clk_en && fwd_rise) ##1 (clk_en && a_to_b_queue_reset_n)
		##1 a_to_b_queue_reset_n |-> left_input_ready && !$past(left_input_ready, 2))
		else $error("input ready not raised two cycles after reset");
	AST_PRESET_64: assert property (fwd_rise && fs == `FS_HH |=>
		fwd_ae_r == `PRESET_HH && fwd_af_r == `PRESET_HH)
		else $error("preset 64 not loaded");
	AST_PROG_FIRST: assert property (prog_wr && pg_r == PG_FWD_AF && clk_en |=>
		fwd_af_r == $past(l_off) && fq.dout == $past(fq.dout))
		else $error("first programming write misrouted");
	AST_PROG_HOLD: assert property (programming |-> !right_input_ready)
		else $error("right input ready high during programming");
	AST_LEFT_MAIL_OUT: assert property (left_data_oe && left_mail_select
		|-> left_data_bus_out == rev_mbox_r)
		else $error("left bus not showing reverse mailbox");
	AST_RIGHT_QUEUE_OUT: assert property (right_data_oe && !right_mail_select
		|-> right_data_bus_out == fq.dout && right_read_not_write)
		else $error("right bus not showing forward output register");
	AST_MAIL_BLOCK: assert property (clk_en && !fmf_r && !fwd_rst && l_wr_m
		|=> $stable(fwd_mbox_r))
		else $error("mailbox overwritten while flag low");
	AST_REV_RESET_FLAGS: assert property (!b_to_a_queue_reset_n |->
		!right_input_ready && !left_output_ready && !left_almost_empty_n
		&& right_almost_full_n && reverse_mail_flag_n)
		else $error("reverse queue flags wrong during reset");
	AST_PRESET_16: assert property (rev_rise && fs == `FS_HL |=>
		rev_ae_r == `PRESET_HL && rev_af_r == `PRESET_HL)
		else $error("preset 16 not loaded");
	AST_PRESET_8: assert property (fwd_rise && fs == `FS_LH |=>
		fwd_ae_r == `PRESET_LH && fwd_af_r == `PRESET_LH)
		else $error("preset 8 not loaded");
	AST_PROG_FWD_AE: assert property (clk_en && prog_wr && pg_r == PG_FWD_AE && !fwd_rise |=>
		fwd_ae_r == $past(l_off))
		else $error("second programming write misrouted");
	AST_PROG_REV_AF: assert property (clk_en && prog_wr && pg_r == PG_REV_AF && !rev_rise |=>
		rev_af_r == $past(l_off))
		else $error("third programming write misrouted");
	AST_PROG_REV_AE: assert property (clk_en && prog_wr && pg_r == PG_REV_AE && !rev_rise |=>
		rev_ae_r == $past(l_off))
		else $error("fourth programming write misrouted");
	AST_MAIL_CLEAR: assert property (clk_en && l_rd_m && !(r_wr_m && rmf_r) |=>
		reverse_mail_flag_n)
		else $error("left mail read did not release reverse mail flag");
	AST_LEFT_QUEUE_OUT: assert property (left_data_oe && !left_mail_select
		|-> left_data_bus_out == rq.dout)
		else $error("left bus not showing reverse output register");

	COV_PROG_DONE: cover property (pg_r == PG_REV_AE && prog_wr && clk_en);
	COV_MAIL_ROUND: cover property (l_wr_m && fmf_r ##[1:8] r_rd_m);
	COV_BOTH_READ: cover property (l_rd_q && r_rd_q);
endmodule // bidir_fifo_ctl
`default_nettype wire

// ### testbench/right_host.sv
`timescale 1ns/1ns
`default_nettype none
module right_host
	import bfifo_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [1:0] op,
	input wire logic mail,
	input wire word_t wd,
	input wire word_t bus_out,
	output logic cs_n,
	output logic rnw,
	output logic en,
	output logic mb,
	output word_t bus_in,
	output word_t rd
);
	logic [2:0] req;
	initial begin
		cs_n = 1'h1;
		rnw = 1'h0;
		en = 1'h0;
		mb = 1'h0;
		bus_in = 32'h0;
	end
	// Request latched at the edge, then held for one whole cycle
	always @(posedge sys_clk) begin
		rd <= bus_out;
		req = {mail, op};
		#1;
		cs_n = (req[1:0] == 2'h0);
		en = (req[1:0] != 2'h0);
		rnw = (req[1:0] == 2'h1);
		mb = req[2];
		// Released bus shows the inverse of its last value
		bus_in = (req[1:0] == 2'h2) ? wd : ~bus_in;
	end
endmodule // right_host
`default_nettype wire

// ### testbench/bidir_fifo_ctl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bidir_fifo_ctl_bench
	import bfifo_pkg::*;
;
	logic sys_clk, l_oe, r_oe, l_ir, l_or, l_ae_n, l_af_n, r_ir, r_or, r_ae_n, r_af_n, f_mf_n, r_mf_n;
	logic r_cs_n, r_rnw, r_en, r_mb;
	logic srst = 1'h1, rf_n = 1'h0, rr_n = 1'h0, s_lo = 1'h1, s_hi = 1'h0;
	logic l_cs_n = 1'h1, l_wnr = 1'h0, l_en = 1'h0, l_mb = 1'h0, r_mail = 1'h0;
	logic [1:0] r_op = 2'h0;
	logic [31:0] seed = 32'hB7FC;
	word_t l_din = 32'h0, r_wd = 32'h0, l_dout, r_din, r_dout, r_rd, got, w;
	word_t q[$];
	int num_errors = 0, checks = 0, n;
	bidir_fifo_ctl bidir_fifo_ctl_i (.sys_clk(sys_clk), .srst(srst), .clk_en(1'h1),
		.a_to_b_queue_reset_n(rf_n), .b_to_a_queue_reset_n(rr_n),
		.offset_select_lo(s_lo), .offset_select_hi(s_hi), .left_chip_select_n(l_cs_n),
		.left_write_not_read(l_wnr), .left_enable(l_en), .left_mail_select(l_mb),
		.left_data_bus_in(l_din), .left_data_bus_out(l_dout), .left_data_oe(l_oe),
		.right_chip_select_n(r_cs_n), .right_read_not_write(r_rnw), .right_enable(r_en),
		.right_mail_select(r_mb), .right_data_bus_in(r_din), .right_data_bus_out(r_dout),
		.right_data_oe(r_oe), .left_input_ready(l_ir), .left_output_ready(l_or),
		.left_almost_empty_n(l_ae_n), .left_almost_full_n(l_af_n), .right_input_ready(r_ir),
		.right_output_ready(r_or), .right_almost_empty_n(r_ae_n), .right_almost_full_n(r_af_n),
		.forward_mail_flag_n(f_mf_n), .reverse_mail_flag_n(r_mf_n));
	right_host right_host_i (.sys_clk(sys_clk), .op(r_op), .mail(r_mail), .wd(r_wd),
		.bus_out(r_dout), .cs_n(r_cs_n), .rnw(r_rnw), .en(r_en), .mb(r_mb), .bus_in(r_din), .rd(r_rd));
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task step;
		@(posedge sys_clk);
		#1;
	endtask
	task lcyc(input logic wnr, input logic mb, input word_t d);
		l_cs_n = 1'h0;
		l_wnr = wnr;
		l_en = 1'h1;
		l_mb = mb;
		l_din = d;
		#8;
		chk(l_oe, !wnr);
		got = l_dout;
		step;
	endtask
	task lidle;
		l_en = 1'h0;
		l_cs_n = 1'h1;
		l_din = ~l_din;
		step;
	endtask
	task rop(input logic [1:0] op, input logic mb, input word_t d);
		r_op = op;
		r_mail = mb;
		r_wd = d;
		step;
		#5;
		chk(r_oe, op == 2'h1);
		r_op = 2'h0;
		step;
	endtask
	task qrst(input logic [1:0] sel, input logic f, input logic r);
		rf_n = !f;
		rr_n = !r;
		{s_hi, s_lo} = sel;
		repeat (4) step;
		chk(f ? {l_ir, r_or, r_ae_n, l_af_n, f_mf_n} : {r_ir, l_or, l_ae_n, r_af_n, r_mf_n}, 5'h3);
		rf_n = 1'h1;
		rr_n = 1'h1;
		chk(f ? l_ir : r_ir, 0);
		step;
		chk(f ? l_ir : r_ir, 0);
		step;
		chk(f ? l_ir : r_ir, 1);
	endtask
	task final_report;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		#1;
		srst = 1'h0;
		qrst(2'h1, 1'h1, 1'h1);
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			q.push_back(seed);
			lcyc(1'h1, 1'h0, seed);
			if (i == 8) begin
				lidle;
				step;
				chk(r_ae_n, 0);
			end
		end
		lidle;
		step;
		chk(r_ae_n, 1);
		repeat (10) begin
			rop(2'h1, 1'h0, 32'h0);
			chk(r_rd, q.pop_front());
		end
		chk(r_or, 0);
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			q.push_back(seed);
			rop(2'h2, 1'h0, seed);
		end
		repeat (5) begin
			lcyc(1'h0, 1'h0, 32'h0);
			chk(got, q.pop_front());
		end
		lidle;
		chk(l_or, 0);
		w = lfsr(seed);
		lcyc(1'h1, 1'h1, w);
		lcyc(1'h1, 1'h1, ~w);
		lidle;
		chk(f_mf_n, 0);
		rop(2'h1, 1'h1, 32'h0);
		chk(r_rd, w);
		chk(f_mf_n, 1);
		rop(2'h2, 1'h1, ~w);
		chk(r_mf_n, 0);
		lcyc(1'h0, 1'h1, 32'h0);
		chk(got, ~w);
		lidle;
		chk(r_mf_n, 1);
		qrst(2'h3, 1'h1, 1'h0);
		n = 0;
		while (l_ir === 1'h1 && n < 600) begin
			seed = lfsr(seed);
			lcyc(1'h1, 1'h0, seed);
			n++;
		end
		lidle;
		chk(n, 513);
		chk(l_af_n, 0);
		qrst(2'h2, 1'h0, 1'h1);
		for (int i = 1; i <= 18; i++) begin
			rop(2'h2, 1'h0, lfsr(seed ^ i));
			if (i >= 17) chk(l_ae_n, i == 18);
		end
		qrst(2'h0, 1'h1, 1'h1);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			lcyc(1'h1, 1'h0, {seed[31:9], 9'(k == 1 ? 2 : 3 + k)});
			chk(r_ir, k == 3);
		end
		chk(r_or, 0);
		for (int i = 0; i < 4; i++) begin
			lcyc(1'h1, 1'h0, lfsr(seed + i));
			if (i == 2) begin
				lidle;
				step;
				chk(r_ae_n, 0);
			end
		end
		lidle;
		step;
		chk(r_ae_n, 1);
		n = 0;
		while (l_ir === 1'h1 && n < 600) begin
			lcyc(1'h1, 1'h0, lfsr(seed ^ n));
			n++;
			if (n == 505 || n == 506) chk(l_af_n, n == 505);
		end
		lidle;
		chk(n, 509);
		n = 0;
		while (r_ir === 1'h1 && n < 600) begin
			rop(2'h2, 1'h0, lfsr(seed ^ n));
			n++;
			if (n == 7 || n == 8) chk(l_ae_n, n == 8);
			if (n == 507 || n == 508) chk(r_af_n, n == 507);
		end
		chk(n, 513);
		final_report;
	end
endmodule // bidir_fifo_ctl_bench
`default_nettype wire
